/* File: hw/cts_pkg.sv */
// Constants, field layouts and types of the complex trigger state machine.
// Assumes a single 100 MHz clock domain and an APB register port.
// Function
// (R1) Arming starts evaluation in state zero
// (R2) Each state holds three destination slots
// (R3) Unit selector 0..2 picks destination slot
// (R4) Per state: 3 tx, 3 rx, timer, async
// (R5) Unit acts only when valid bit set
// (R6) Byte pattern compare under care mask
// (R7) Criterion selects pass/fail for CRC slots
// (R8) Slot one first CRC, two second
// (R9) Data payload slot two tests END/EDB
// (R10) Error class criterion is error bitmask
// (R11) Criterion rejected for other packet classes
// (R12) Drop refused on timer, async, error units
// (R13) Jump to invalid destination slot rejected
// (R14) At most one supply threshold overall
// (R15) Supply trigger needs monitoring enabled first
// (R16) Match asserts trigger pin when enabled
// (R17) Check-only verifies without loading hardware
// (R18) Pattern and mask lengths must agree
// (R19) Excess data resources rejected, nothing loaded
// (R20) Jump moves to chosen state's units
// (R21) Header: CRC-16 then CRC-5; command: two CRC-5
package cts_pkg;
	localparam int NUM_STATES = 4;
	localparam int NUM_UNITS = 8;
	localparam int NUM_SLOTS = 3;
	localparam int PAT_BYTES = 4;
	localparam logic [2:0] UNIT_TIMER = 3'h6;
	localparam logic [2:0] UNIT_ASYNC = 3'h7;
	// Register map
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CMD = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [7:0] GOTO_PAGE = 8'h01;
	localparam logic [3:0] UNIT_PAGE = 4'h1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_ARM = 0;
	localparam int CTRL_EXTOUT = 1;
	localparam int CTRL_IVMON = 2;
	localparam int CMD_LOAD = 0;
	localparam int CMD_CHECK = 1;
	localparam int STS_DONE = 12;
	localparam int STS_LOADED = 13;
	localparam int STS_ARMED = 14;
	localparam int STS_STATE_LSB = 16;
	localparam int STS_TRIG_LSB = 20;
	// Unit control word fields
	localparam int U_VALID = 0;
	localparam int U_CLASS_LSB = 1;
	localparam int U_CRIT_LSB = 4;
	localparam int U_PLEN_LSB = 7;
	localparam int U_MLEN_LSB = 10;
	localparam int U_CARE_LSB = 13;
	localparam int U_JUMP = 17;
	localparam int U_DROP = 18;
	localparam int U_EXT = 19;
	localparam int U_SEL_LSB = 20;
	localparam int U_VBUS = 22;
	// Goto word: slot k at bits 4k+1:4k, valid at 4k+2
	localparam int G_STRIDE = 4;
	localparam int G_VALID = 2;
	// Packet classes
	localparam logic [2:0] CLS_NONE = 3'h0;
	localparam logic [2:0] link_command_class = 3'h1;
	localparam logic [2:0] header_packet_class = 3'h2;
	localparam logic [2:0] data_packet_class = 3'h3;
	localparam logic [2:0] header_data_packet_class = 3'h4;
	localparam logic [2:0] CLS_ERROR = 3'h5;
	// Criterion codes for CRC-bearing classes
	localparam logic [2:0] CRIT_ANY = 3'h0;
	localparam logic [2:0] CRIT_1_OK = 3'h1;
	localparam logic [2:0] CRIT_2_OK = 3'h2;
	localparam logic [2:0] CRIT_BOTH_OK = 3'h3;
	localparam logic [2:0] CRIT_EITHER_BAD = 3'h4;
	localparam logic [2:0] CRIT_1_BAD = 3'h5;
	localparam logic [2:0] CRIT_2_BAD = 3'h6;
	localparam logic [2:0] CRIT_BOTH_BAD = 3'h7;
	// Error class bitmask: crc, framing, unknown
	localparam int EMASK_W = 3;
	// Check error bits
	localparam int ERR_W = 9;
	localparam int E_DEST = 0;
	localparam int E_SEL = 1;
	localparam int E_FIELD = 2;
	localparam int E_DROP = 3;
	localparam int E_CRIT = 4;
	localparam int E_RES = 5;
	localparam int E_MULTI_VBUS = 6;
	localparam int E_IVMON = 7;
	localparam int E_CLASS = 8;
	typedef enum logic {CTS_IDLE, CTS_RUN} cts_run_t;
endpackage : cts_pkg

/* File: hw/cts_data_unit.sv */
// One data match unit: class, masked pattern and CRC/error criterion.
// Assumes packet fields are valid for the cycle in which pkt_valid is high.
`timescale 1ns/1ps
module cts_data_unit (
	input wire logic [31:0] ctrl, // Unit control word
	input wire logic [31:0] pat, // Pattern bytes
	input wire logic pkt_valid, // Packet end strobe
	input wire logic [2:0] pkt_class, // Observed class
	input wire logic [31:0] pkt_data, // First packet bytes
	input wire logic crc1_ok, // First CRC slot passed
	input wire logic crc2_ok, // Second slot passed or END seen
	input wire logic [cts_pkg::EMASK_W-1:0] err_flags, // Observed errors
	output logic hit // Unit matches this packet
);
	import cts_pkg::*;
	logic [PAT_BYTES-1:0] byte_ok;
	wire [2:0] cls = ctrl[U_CLASS_LSB +: 3];
	wire [2:0] crit = ctrl[U_CRIT_LSB +: 3];
	wire [PAT_BYTES-1:0] care = ctrl[U_CARE_LSB +: PAT_BYTES];
	genvar b;
	generate
		for (b = 0; b < PAT_BYTES; b++) begin : g_byte
			assign byte_ok[b] = !care[b] || (pkt_data[8*b +: 8] == pat[8*b +: 8]); // R6
		end
	endgenerate
	// Slot two of a data payload carries END as pass, EDB as fail
	logic crit_ok;
	always_comb begin
		case (crit) // R7 R8 R9 R21
			CRIT_ANY: crit_ok = 1'b1;
			CRIT_1_OK: crit_ok = crc1_ok;
			CRIT_2_OK: crit_ok = crc2_ok;
			CRIT_BOTH_OK: crit_ok = crc1_ok && crc2_ok;
			CRIT_EITHER_BAD: crit_ok = !crc1_ok || !crc2_ok;
			CRIT_1_BAD: crit_ok = !crc1_ok;
			CRIT_2_BAD: crit_ok = !crc2_ok;
			default: crit_ok = !crc1_ok && !crc2_ok;
		endcase
	end
	wire err_ok = |(err_flags & crit[EMASK_W-1:0]); // R10
	wire cls_ok = (pkt_class == cls);
	wire cond_ok = (cls == CLS_ERROR) ? err_ok : crit_ok;
	assign hit = ctrl[U_VALID] && pkt_valid && cls_ok && (&byte_ok) && cond_ok; // R5
endmodule : cts_data_unit

/* File: hw/cts_trigger.sv */
// Complex trigger state machine with configuration check and APB registers.
// Assumes packet and event inputs are synchronous to clock.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module cts_trigger (
	input wire logic clock, // 100 MHz clock
	input wire logic rst, // Async reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic tx_pkt_valid, // Tx packet end strobe
	input wire logic [2:0] tx_pkt_class, // Tx class
	input wire logic [31:0] tx_pkt_data, // Tx first bytes
	input wire logic tx_crc1_ok, // Tx slot one pass
	input wire logic tx_crc2_ok, // Tx slot two pass
	input wire logic [cts_pkg::EMASK_W-1:0] tx_err_flags, // Tx errors
	input wire logic rx_pkt_valid, // Rx packet end strobe
	input wire logic [2:0] rx_pkt_class, // Rx class
	input wire logic [31:0] rx_pkt_data, // Rx first bytes
	input wire logic rx_crc1_ok, // Rx slot one pass
	input wire logic rx_crc2_ok, // Rx slot two pass
	input wire logic [cts_pkg::EMASK_W-1:0] rx_err_flags, // Rx errors
	input wire logic async_event, // Async event strobe
	output logic trig_out, // External trigger pulse
	output logic drop_pkt, // Drop current packet pulse
	output logic match_pulse // Any unit hit pulse
);
	import cts_pkg::*;

	// Staged and loaded configuration
	logic [31:0] stg_ctrl_ff [NUM_STATES][NUM_UNITS];
	logic [31:0] stg_pat_ff [NUM_STATES][NUM_UNITS];
	logic [31:0] stg_goto_ff [NUM_STATES];
	logic [31:0] act_ctrl_ff [NUM_STATES][NUM_UNITS];
	logic [31:0] act_pat_ff [NUM_STATES][NUM_UNITS];
	logic [31:0] act_goto_ff [NUM_STATES];
	logic [31:0] ctrl_ff;
	logic [ERR_W-1:0] err_ff;
	logic done_ff;
	logic loaded_ff;
	logic [1:0] cur_ff;
	cts_run_t run_ff;
	logic [31:0] timer_ff;
	logic [11:0] trig_cnt_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic trig_ff;
	logic drop_ff;
	logic match_ff;

	function automatic logic is_goto(input logic [11:0] a);
		return a[11:4] == GOTO_PAGE;
	endfunction : is_goto

	function automatic logic is_unit(input logic [11:0] a);
		return a[11:8] == UNIT_PAGE;
	endfunction : is_unit

	function automatic logic [1:0] unit_sel(input logic [31:0] w);
		return w[U_SEL_LSB +: 2];
	endfunction : unit_sel

	function automatic logic [2:0] unit_cls(input logic [31:0] w);
		return w[U_CLASS_LSB +: 3];
	endfunction : unit_cls

	function automatic logic special_unit(input int u);
		return u >= int'(UNIT_TIMER);
	endfunction : special_unit

	// Bus decode
	wire setup_done = psel && penable && !pready_ff;
	wire bus_take = psel && penable && pready_ff;
	wire wr_take = bus_take && pwrite;
	wire hit_ctrl = paddr == ADDR_CTRL;
	wire hit_cmd = paddr == ADDR_CMD;
	wire hit_sts = paddr == ADDR_STATUS;
	// Byte lanes are not decoded, so addresses off a word boundary are refused
	wire aligned = paddr[1:0] == 2'h0;
	wire hit_goto = is_goto(paddr) && aligned;
	wire hit_unit = is_unit(paddr) && aligned;
	wire mapped = hit_ctrl || hit_cmd || hit_sts || hit_goto || hit_unit;
	wire [1:0] a_gstate = paddr[3:2];
	wire [1:0] a_ustate = paddr[7:6];
	wire [2:0] a_unit = paddr[5:3];
	wire a_word = paddr[2];
	wire cmd_load = wr_take && hit_cmd && pwdata[CMD_LOAD];
	wire cmd_check = wr_take && hit_cmd && pwdata[CMD_CHECK];
	wire cmd_any = cmd_load || cmd_check;

	// Consistency check over the staged image
	logic [ERR_W-1:0] chk_err;
	logic [2:0] vbus_cnt;
	logic [31:0] cu;
	logic [1:0] sel;
	logic [2:0] ucls;
	logic [2:0] plen;
	logic [2:0] mlen;
	logic special;
	always_comb begin
		chk_err = '0;
		vbus_cnt = 3'h0;
		cu = 32'h0000_0000;
		sel = 2'h0;
		ucls = 3'h0;
		plen = 3'h0;
		mlen = 3'h0;
		special = 1'b0;
		for (int s = 0; s < NUM_STATES; s++) begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				cu = stg_ctrl_ff[s][u];
				sel = unit_sel(cu);
				ucls = unit_cls(cu);
				plen = cu[U_PLEN_LSB +: 3];
				mlen = cu[U_MLEN_LSB +: 3];
				// Timer and async units carry no class or pattern
				special = special_unit(u);
				if (cu[U_VALID]) begin // R5
					if (cu[U_JUMP] && sel > 2'h2) begin
						chk_err[E_SEL] = 1'b1; // R3
					end
					if (cu[U_JUMP] && sel <= 2'h2
							&& !stg_goto_ff[s][32'(sel) * G_STRIDE + G_VALID]) begin
						chk_err[E_DEST] = 1'b1; // R13
					end
					if (cu[U_DROP] && (special || ucls == CLS_ERROR)) begin
						chk_err[E_DROP] = 1'b1; // R12
					end
					// Saturate at two so many flags cannot wrap to zero
					if (cu[U_VBUS] && vbus_cnt != 3'h2) begin
						vbus_cnt = vbus_cnt + 3'h1;
					end
					if (!special) begin
						if (ucls == CLS_NONE || ucls > CLS_ERROR) begin
							chk_err[E_CLASS] = 1'b1;
							if (cu[U_CRIT_LSB +: 3] != CRIT_ANY) begin
								chk_err[E_CRIT] = 1'b1; // R11
							end
						end
						if (plen != mlen) begin
							chk_err[E_FIELD] = 1'b1; // R18
						end
						if (plen > 3'(PAT_BYTES)) begin
							chk_err[E_RES] = 1'b1; // R19
						end
					end
				end
			end
		end
		if (vbus_cnt > 3'h1) begin
			chk_err[E_MULTI_VBUS] = 1'b1; // R14
		end
		if (vbus_cnt != 3'h0 && !ctrl_ff[CTRL_IVMON]) begin
			chk_err[E_IVMON] = 1'b1; // R15
		end
	end
	wire load_ok = cmd_load && !cmd_check && chk_err == '0;

	// Unit evaluation in the current state
	logic [NUM_UNITS-1:0] unit_hit;
	genvar g;
	generate
		for (g = 0; g < 2 * NUM_SLOTS; g++) begin : g_data
			localparam bit IS_TX = g < NUM_SLOTS;
			cts_data_unit u_unit (
				.ctrl(act_ctrl_ff[cur_ff][g]),
				.pat(act_pat_ff[cur_ff][g]),
				.pkt_valid(IS_TX ? tx_pkt_valid : rx_pkt_valid),
				.pkt_class(IS_TX ? tx_pkt_class : rx_pkt_class),
				.pkt_data(IS_TX ? tx_pkt_data : rx_pkt_data),
				.crc1_ok(IS_TX ? tx_crc1_ok : rx_crc1_ok),
				.crc2_ok(IS_TX ? tx_crc2_ok : rx_crc2_ok),
				.err_flags(IS_TX ? tx_err_flags : rx_err_flags),
				.hit(unit_hit[g])
			); // R4
		end
	endgenerate
	wire [31:0] tmr_ctrl = act_ctrl_ff[cur_ff][UNIT_TIMER];
	wire [31:0] asy_ctrl = act_ctrl_ff[cur_ff][UNIT_ASYNC];
	wire [31:0] tmr_pat = act_pat_ff[cur_ff][UNIT_TIMER];
	assign unit_hit[UNIT_TIMER] = tmr_ctrl[U_VALID]
		&& timer_ff == tmr_pat; // R4
	assign unit_hit[UNIT_ASYNC] = asy_ctrl[U_VALID] && async_event; // R5
	wire running = run_ff == CTS_RUN;

	// Lowest firing unit with a jump wins
	logic jump;
	logic [1:0] jump_sel;
	logic ext_any;
	logic drop_any;
	always_comb begin
		jump = 1'b0;
		jump_sel = 2'h0;
		ext_any = 1'b0;
		drop_any = 1'b0;
		for (int u = NUM_UNITS - 1; u >= 0; u--) begin
			if (running && unit_hit[u]) begin
				if (act_ctrl_ff[cur_ff][u][U_JUMP]) begin
					jump = 1'b1;
					jump_sel = unit_sel(act_ctrl_ff[cur_ff][u]); // R3
				end
				ext_any = ext_any || act_ctrl_ff[cur_ff][u][U_EXT];
				drop_any = drop_any || act_ctrl_ff[cur_ff][u][U_DROP];
			end
		end
	end
	wire [31:0] cur_goto = act_goto_ff[cur_ff];
	wire [1:0] jump_dest = cur_goto[32'(jump_sel) * G_STRIDE +: 2]; // R2
	wire armed = ctrl_ff[CTRL_ARM] && loaded_ff;

	// Read mux
	wire [31:0] sts_word = {trig_cnt_ff, 2'h0, cur_ff, 1'b0, armed, loaded_ff,
		done_ff, 3'h0, err_ff};
	wire [31:0] unit_word = a_word ? stg_pat_ff[a_ustate][a_unit]
		: stg_ctrl_ff[a_ustate][a_unit];
	wire [31:0] rd_word = hit_ctrl ? ctrl_ff
		: hit_sts ? sts_word
		: hit_goto ? stg_goto_ff[a_gstate]
		: hit_unit ? unit_word
		: 32'h0000_0000;

	// Bus slave
	wire bad_addr = setup_done && !mapped;
	wire rd_setup = setup_done && !pwrite;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup_done;
			pslverr_ff <= bad_addr;
			prdata_ff <= rd_setup ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_ff <= CTRL_RESET;
		end else if (wr_take && hit_ctrl) begin
			ctrl_ff <= pwdata;
		end
	end

	// Staged image writes
	// Matcher sees these only after a clean load
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stg_ctrl_ff <= '{default: '0};
			stg_pat_ff <= '{default: '0};
			stg_goto_ff <= '{default: '0};
		end else if (wr_take && hit_unit && !a_word) begin
			stg_ctrl_ff[a_ustate][a_unit] <= pwdata;
		end else if (wr_take && hit_unit) begin
			stg_pat_ff[a_ustate][a_unit] <= pwdata;
		end else if (wr_take && hit_goto) begin
			stg_goto_ff[a_gstate] <= pwdata;
		end
	end

	// Check result and load into the matching hardware
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			err_ff <= '0;
			done_ff <= 1'b0;
			loaded_ff <= 1'b0;
		end else if (cmd_any) begin
			err_ff <= chk_err; // R17
			done_ff <= 1'b1;
			loaded_ff <= loaded_ff || load_ok; // R19
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			act_ctrl_ff <= '{default: '0};
			act_pat_ff <= '{default: '0};
			act_goto_ff <= '{default: '0};
		end else if (load_ok) begin
			act_ctrl_ff <= stg_ctrl_ff; // R17
			act_pat_ff <= stg_pat_ff;
			act_goto_ff <= stg_goto_ff;
		end
	end

	// Trigger sequencer
	// Timer restarts on every state entry
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			run_ff <= CTS_IDLE;
			cur_ff <= 2'h0;
			timer_ff <= 32'h0000_0000;
		end else begin
			case (run_ff)
				CTS_IDLE: begin
					cur_ff <= 2'h0; // R1
					timer_ff <= 32'h0000_0000;
					if (armed && !load_ok) begin
						run_ff <= CTS_RUN;
					end
				end
				CTS_RUN: begin
					if (!armed || load_ok) begin
						run_ff <= CTS_IDLE;
					end else if (jump) begin
						cur_ff <= jump_dest; // R20
						timer_ff <= 32'h0000_0000;
					end else begin
						timer_ff <= timer_ff + 32'h0000_0001;
					end
				end
				default: run_ff <= CTS_IDLE;
			endcase
		end
	end

	// Event outputs
	wire trig_fire = ext_any && ctrl_ff[CTRL_EXTOUT]; // R16
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trig_ff <= 1'b0;
			drop_ff <= 1'b0;
			match_ff <= 1'b0;
			trig_cnt_ff <= 12'h000;
		end else begin
			trig_ff <= trig_fire; // R16
			drop_ff <= drop_any;
			match_ff <= running && |unit_hit;
			if (trig_fire) begin
				trig_cnt_ff <= trig_cnt_ff + 12'h001;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign trig_out = trig_ff;
	assign drop_pkt = drop_ff;
	assign match_pulse = match_ff;
endmodule : cts_trigger

/* File: tb/cts_trigger_monitor.sv */
// Checker for the trigger block, bound to its top-level ports.
// Assumes one clock domain; CTRL is shadowed from completed APB writes.
`timescale 1ns/1ps
module cts_trigger_monitor (
	input wire logic clock, // Clock
	input wire logic rst, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic tx_pkt_valid, // Tx strobe
	input wire logic rx_pkt_valid, // Rx strobe
	input wire logic trig_out, // Trigger
	input wire logic drop_pkt, // Drop
	input wire logic match_pulse // Hit
);
	import cts_pkg::*;
	logic [31:0] ctrl_ff;
	logic [31:0] nxt_ctrl;
	wire logic ctrl_wr = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
	assign nxt_ctrl = ctrl_wr ? pwdata : ctrl_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_ff <= CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (rst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && !pready;
	endsequence
	property p_one_wait;
		s_setup ##1 s_access |=> pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("no ready after wait");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
	property p_err_unmapped;
		pready && paddr == 12'h00C |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_rdata_idle;
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_trig_ext;
		trig_out |-> match_pulse && $past(ctrl_ff[CTRL_EXTOUT]);
	endproperty
	a_trig_ext: assert property (p_trig_ext) else $error("bad trigger");
	property p_drop_data;
		drop_pkt |-> match_pulse && $past(tx_pkt_valid || rx_pkt_valid);
	endproperty
	a_drop_data: assert property (p_drop_data) else $error("bad drop");
	property p_match_armed;
		match_pulse |-> $past(ctrl_ff[CTRL_ARM]);
	endproperty
	a_match_armed: assert property (p_match_armed) else $error("hit unarmed");
endmodule : cts_trigger_monitor
bind cts_trigger cts_trigger_monitor u_mon (
	.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_pkt_valid(tx_pkt_valid), .rx_pkt_valid(rx_pkt_valid), .trig_out(trig_out),
	.drop_pkt(drop_pkt), .match_pulse(match_pulse)
);

/* File: tb/cts_link_model.sv */
// Link-side model: one direction of finished packets for the matcher.
// Assumes the caller gives class, first bytes, slot results and error flags.
`timescale 1ns/1ps
module cts_link_model (
	input wire logic clock, // Bench clock
	output logic valid, // Packet end strobe
	output logic [2:0] cls, // Packet class
	output logic [31:0] data, // First bytes, byte0 low
	output logic crc1_ok, // First CRC slot
	output logic crc2_ok, // Second slot or END
	output logic [2:0] err // Crc, framing, unknown
);
	initial begin
		valid = 1'b0;
		cls = 3'h0;
		data = 32'h0000_0000;
		crc1_ok = 1'b0;
		crc2_ok = 1'b0;
		err = 3'h0;
	end
	task automatic send(input logic [2:0] k, input logic [31:0] d, input logic [1:0] ok,
		input logic [2:0] e);
		@(posedge clock);
		valid <= 1'b1;
		cls <= k;
		data <= d;
		crc1_ok <= ok[1];
		crc2_ok <= ok[0];
		err <= e;
		@(posedge clock);
		// Fields are stale once the strobe drops
		valid <= 1'b0;
		cls <= ~k;
		data <= ~d;
		crc1_ok <= ~ok[1];
		crc2_ok <= ~ok[0];
		err <= ~e;
		repeat (3) @(posedge clock);
	endtask : send
endmodule : cts_link_model

/* File: tb/cts_trigger_tb.sv */
// Bench for the trigger block: APB set-up, checks and link traffic.
// Assumes the two link models and the bound checker.
`timescale 1ns/1ps
module cts_trigger_tb;
	import cts_pkg::*;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, perr, async_event;
	logic trig_out, drop_pkt, match_pulse, tx_valid, tx_c1, tx_c2, rx_valid, rx_c1, rx_c2;
	logic [2:0] tx_cls, tx_err, rx_cls, rx_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, tx_dat, rx_dat;
	int failures, samples_checked, n_match, n_trig, n_drop;
	cts_trigger u_dut (
		.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_pkt_valid(tx_valid), .tx_pkt_class(tx_cls), .tx_pkt_data(tx_dat),
		.tx_crc1_ok(tx_c1), .tx_crc2_ok(tx_c2), .tx_err_flags(tx_err),
		.rx_pkt_valid(rx_valid), .rx_pkt_class(rx_cls), .rx_pkt_data(rx_dat),
		.rx_crc1_ok(rx_c1), .rx_crc2_ok(rx_c2), .rx_err_flags(rx_err),
		.async_event(async_event), .trig_out(trig_out), .drop_pkt(drop_pkt),
		.match_pulse(match_pulse)
	);
	cts_link_model u_tx (.clock(clock), .valid(tx_valid), .cls(tx_cls), .data(tx_dat),
		.crc1_ok(tx_c1), .crc2_ok(tx_c2), .err(tx_err));
	cts_link_model u_rx (.clock(clock), .valid(rx_valid), .cls(rx_cls), .data(rx_dat),
		.crc1_ok(rx_c1), .crc2_ok(rx_c2), .err(rx_err));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (match_pulse === 1'b1) n_match <= n_match + 1;
		if (trig_out === 1'b1) n_trig <= n_trig + 1;
		if (drop_pkt === 1'b1) n_drop <= n_drop + 1;
	end
	function automatic logic [31:0] uc(input logic [2:0] c, k, pl, ml, input logic [3:0] ca,
		input logic [5:0] fl);
		return 32'h1 | 32'(c) << U_CLASS_LSB | 32'(k) << U_CRIT_LSB | 32'(pl) << U_PLEN_LSB
			| 32'(ml) << U_MLEN_LSB | 32'(ca) << U_CARE_LSB | 32'(fl) << U_JUMP;
	endfunction : uc
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clock);
		if (n == 20) begin
			failures++;
			report_and_stop();
		end
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask : rd
	task automatic st(input logic [31:0] s);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("state", s, (q >> STS_STATE_LSB) & 32'h3);
		chk("armed", 32'h1, {31'h0, q[STS_ARMED]});
	endtask : st
	task automatic bad(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
		wr(a, v);
		wr(ADDR_CMD, 32'h1 << CMD_CHECK);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("check_errors", m, q & 32'h0000_01FF);
		wr(a, 32'h0);
	endtask : bad
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		{rst, psel, penable, pwrite, async_event} = 5'h10;
		{paddr, pwdata} = 44'h0;
		{failures, samples_checked, n_match, n_trig, n_drop} = '0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(ADDR_CTRL, CTRL_RESET, "ctrl");
		rd(ADDR_STATUS, 32'h0, "status");
		rd(12'h00C, 32'h0, "unmapped");
		chk("slverr", 32'h1, {31'h0, perr});
		wr(12'h100, uc(data_packet_class, CRIT_2_OK, 3'h4, 3'h4, 4'h5, 6'h0F));
		wr(12'h104, 32'h00AA_0055);
		wr(12'h010, 32'h0000_0006 << G_STRIDE);
		wr(12'h198, uc(CLS_ERROR, 3'h6, 3'h0, 3'h0, 4'h0, 6'h00));
		wr(ADDR_CMD, 32'h1 << CMD_CHECK);
		rd(ADDR_STATUS, 32'h1 << STS_DONE, "check_only");
		wr(ADDR_CMD, 32'h1 << CMD_LOAD);
		rd(ADDR_STATUS, 32'h1 << STS_DONE | 32'h1 << STS_LOADED, "loaded");
		bad(12'h1C0, uc(data_packet_class, 3'h0, 3'h0, 3'h0, 4'h0, 6'h19), 32'h1 << E_SEL);
		bad(12'h1C0, uc(data_packet_class, 3'h0, 3'h2, 3'h3, 4'h0, 6'h0), 32'h1 << E_FIELD);
		bad(12'h1F0, uc(CLS_NONE, 3'h0, 3'h0, 3'h0, 4'h0, 6'h02), 32'h1 << E_DROP);
		bad(12'h1C0, uc(CLS_ERROR, 3'h1, 3'h0, 3'h0, 4'h0, 6'h02), 32'h1 << E_DROP);
		bad(12'h1C0, uc(CLS_NONE, CRIT_1_OK, 3'h0, 3'h0, 4'h0, 6'h0),
			32'h1 << E_CRIT | 32'h1 << E_CLASS);
		bad(12'h1C0, uc(data_packet_class, 3'h0, 3'h5, 3'h5, 4'h0, 6'h0), 32'h1 << E_RES);
		bad(12'h1C0, uc(data_packet_class, 3'h0, 3'h0, 3'h0, 4'h0, 6'h01), 32'h1 << E_DEST);
		bad(12'h1C8, uc(data_packet_class, 3'h0, 3'h0, 3'h0, 4'h0, 6'h20), 32'h1 << E_IVMON);
		wr(ADDR_CTRL, 32'h1 << CTRL_IVMON);
		wr(12'h1C8, uc(data_packet_class, 3'h0, 3'h0, 3'h0, 4'h0, 6'h20));
		bad(12'h1D0, uc(data_packet_class, 3'h0, 3'h0, 3'h0, 4'h0, 6'h20), 32'h1 << E_MULTI_VBUS);
		wr(12'h1C8, 32'h0);
		wr(ADDR_CTRL, 32'h0000_0007);
		st(32'h0);
		u_tx.send(data_packet_class, 32'hFFAA_EE55, 2'b10, 3'h0);
		u_tx.send(data_packet_class, 32'hFFAA_EE54, 2'b01, 3'h0);
		chk("no_hit", 32'h0, n_match);
		u_tx.send(data_packet_class, 32'h33AA_7755, 2'b01, 3'h0);
		chk("trig", 32'h1, n_trig);
		chk("drop", 32'h1, n_drop);
		st(32'h2);
		u_tx.send(data_packet_class, 32'h33AA_7755, 2'b01, 3'h0);
		u_rx.send(CLS_ERROR, 32'h0, 2'b00, 3'h1);
		chk("match", 32'h1, n_match);
		u_rx.send(CLS_ERROR, 32'h0, 2'b00, 3'h4);
		chk("match", 32'h2, n_match);
		chk("trig", 32'h1, n_trig);
		wr(12'h130, uc(CLS_NONE, 3'h0, 3'h0, 3'h0, 4'h0, 6'h09));
		wr(12'h134, 32'h0000_0028);
		wr(12'h138, uc(CLS_NONE, 3'h0, 3'h0, 3'h0, 4'h0, 6'h04));
		wr(ADDR_CMD, 32'h1 << CMD_LOAD);
		st(32'h0);
		@(posedge clock);
		async_event <= 1'b1;
		@(posedge clock);
		async_event <= 1'b0;
		repeat (3) @(posedge clock);
		chk("async_trig", 32'h2, n_trig);
		repeat (40) @(posedge clock);
		st(32'h2);
		chk("timer_match", 32'h4, n_match);
		report_and_stop();
	end
endmodule : cts_trigger_tb
